// ---- core/instruction_decoder.sv ----
// Instruction decoder for an 8-bit core with 14-bit words, reached over APB.
// Assumes one clock, asynchronous active-low reset and an APB master that holds each request.
// Function
// - Byte register ops: destination bit zero selects accumulator, one selects file register.
// - Bit ops carry a 3-bit bit position and 7-bit file address.
// - Relative branch displacement is the signed 9-bit low field.
// - Pointer offset ops use a one-bit pointer select and 6-bit low offset.
// - Counter changes or true conditional tests cost two cycles, second is idle.
// - Indirect port access with pointer top bit set adds one cycle.
// - Add-with-carry decodes from 11 1101 and updates carry, digit carry, zero.
// - Subtract-with-borrow decodes from 11 1011 and updates carry, digit carry, zero.
// - Decrement/increment skip decode from 00 1011/00 1111, skip on zero, no flags.
// - Bit tests skip when bit clear (01 10) or set (01 11).
// - Upper counter latch load decodes from 11 0001 1, 7-bit literal, no flags.
// - Subtract accumulator from literal decodes from 11 1100, sets carry, digit carry, zero.
// - Exclusive-OR accumulator with register decodes from 00 0110, zero flag only.
// - Inclusive-OR literal with accumulator decodes from 11 1000, zero flag only.
// - Rotates via carry decode from 00 1101 left, 00 1100 right, carry only.
`include "decoder_regs.svh"

module instruction_decoder (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);
   import decoder_pkg::*;

   localparam logic [2:0] FL_NONE = 3'h0;
   localparam logic [2:0] FL_Z = 3'h1 << `FLAG_Z;
   localparam logic [2:0] FL_C = 3'h1 << `FLAG_C;
   localparam logic [2:0] FL_CZ = FL_C | FL_Z;
   localparam logic [2:0] FL_ALL = FL_C | FL_Z | (3'h1 << `FLAG_DIGIT_CARRY);

   function automatic decoded_t file_form(input op_t op, input logic [13:0] w, input logic [2:0] fl);
      decoded_t d;
      d = '0;
      d.op = op;
      d.dest = w[7];
      d.faddr = w[6:0];
      d.flags = fl;
      d.file_op = 1'b1;
      return d;
   endfunction

   function automatic decoded_t lit_form(input op_t op, input logic [10:0] k, input logic [2:0] fl);
      decoded_t d;
      d = '0;
      d.op = op;
      d.lit = k;
      d.flags = fl;
      return d;
   endfunction

   function automatic decoded_t decode(input logic [13:0] w);
      decoded_t d;
      d = lit_form(op_illegal, 11'h000, FL_NONE);
      casez (w)
         14'b00_0111_????_????: d = file_form(op_add_acc_register, w, FL_ALL);
         14'b11_1101_????_????: d = file_form(op_add_with_carry_to_register, w, FL_ALL);
         14'b00_0101_????_????: d = file_form(op_and_acc_register, w, FL_Z);
         14'b11_0111_????_????: d = file_form(op_arith_shift_right, w, FL_CZ);
         14'b11_0101_????_????: d = file_form(op_logic_shift_left, w, FL_CZ);
         14'b11_0110_????_????: d = file_form(op_logic_shift_right, w, FL_CZ);
         14'b00_0001_1???_????: d = file_form(op_clear_register, w, FL_Z);
         14'b00_0001_0000_00??: d = lit_form(op_clear_acc, 11'h000, FL_Z);
         14'b00_1001_????_????: d = file_form(op_complement_register, w, FL_Z);
         14'b00_0011_????_????: d = file_form(op_decrement_register, w, FL_Z);
         14'b00_1010_????_????: d = file_form(op_increment_register, w, FL_Z);
         14'b00_0100_????_????: d = file_form(op_inclusive_or_acc_register, w, FL_Z);
         14'b00_1000_????_????: d = file_form(op_move_register, w, FL_Z);
         14'b00_0000_1???_????: d = file_form(op_move_acc_to_register, w, FL_NONE);
         14'b00_1101_????_????: d = file_form(op_rotate_left_via_carry, w, FL_C);
         14'b00_1100_????_????: d = file_form(op_rotate_right_via_carry, w, FL_C);
         14'b00_0010_????_????: d = file_form(op_subtract_acc_register, w, FL_ALL);
         14'b11_1011_????_????: d = file_form(op_subtract_with_borrow_register, w, FL_ALL);
         14'b00_1110_????_????: d = file_form(op_swap_nibbles, w, FL_NONE);
         14'b00_0110_????_????: d = file_form(op_exclusive_or_acc_register, w, FL_Z);
         14'b00_1011_????_????: d = file_form(op_decrement_skip_if_zero, w, FL_NONE);
         14'b00_1111_????_????: d = file_form(op_increment_skip_if_zero, w, FL_NONE);
         14'b01_????_????_????: begin
            unique case (w[11:10])
               2'b00: d = file_form(op_bit_clear, w, FL_NONE);
               2'b01: d = file_form(op_bit_set, w, FL_NONE);
               2'b10: d = file_form(op_bit_test_skip_if_clear, w, FL_NONE);
               2'b11: d = file_form(op_bit_test_skip_if_set, w, FL_NONE);
            endcase
            d.dest = 1'b1;
            d.bitpos = w[9:7];
         end
         14'b11_1110_????_????: d = lit_form(op_add_literal_acc, {3'h0, w[7:0]}, FL_ALL);
         14'b11_1001_????_????: d = lit_form(op_and_literal_acc, {3'h0, w[7:0]}, FL_Z);
         14'b11_1000_????_????: d = lit_form(op_inclusive_or_literal_acc, {3'h0, w[7:0]}, FL_Z);
         14'b00_0000_001?_????: d = lit_form(op_load_bank_select, {6'h00, w[4:0]}, FL_NONE);
         14'b11_0001_1???_????: d = lit_form(op_load_upper_counter_latch, {4'h0, w[6:0]}, FL_NONE);
         14'b11_0000_????_????: d = lit_form(op_move_literal_acc, {3'h0, w[7:0]}, FL_NONE);
         14'b11_1100_????_????: d = lit_form(op_subtract_acc_from_literal, {3'h0, w[7:0]}, FL_ALL);
         14'b11_1010_????_????: d = lit_form(op_exclusive_or_literal_acc, {3'h0, w[7:0]}, FL_Z);
         14'b10_0???_????_????: begin
            d = lit_form(op_call, w[10:0], FL_NONE);
            d.pc_mod = 1'b1;
         end
         14'b10_1???_????_????: begin
            d = lit_form(op_jump, w[10:0], FL_NONE);
            d.pc_mod = 1'b1;
         end
         14'b11_001?_????_????: begin
            d = lit_form(op_relative_branch, {2'h0, w[8:0]}, FL_NONE);
            d.pc_mod = 1'b1;
         end
         14'b11_0001_0???_????: begin
            d = lit_form(op_pointer_add_offset, {5'h00, w[5:0]}, FL_NONE);
            d.ptr_sel = w[6];
         end
         14'b11_1111_????_????: begin
            d = lit_form(op_pointer_move_indexed, {5'h00, w[5:0]}, FL_Z);
            d.ptr_sel = w[6];
            d.dest = w[7];
         end
         14'h0000: d = lit_form(op_nop, 11'h000, FL_NONE);
         default: d = lit_form(op_illegal, 11'h000, FL_NONE);
      endcase
      return d;
   endfunction

   logic [13:0] instr_ff, nxt_instr;
   logic [7:0] operand_ff, nxt_operand;
   logic [1:0] ptr_msb_ff, nxt_ptr_msb;
   logic [31:0] prdata_ff, nxt_prdata;
   logic pready_ff, nxt_pready;
   logic pslverr_ff, nxt_pslverr;

   decoded_t dec;
   logic skip_taken;
   logic extra_cycle;
   logic [1:0] cycles;
   logic [15:0] disp;
   logic mapped;
   logic [31:0] rd_word;

   always_comb begin
      dec = decode(instr_ff);
      // The operand register holds the file value the datapath fetched for the test
      unique case (dec.op)
         op_decrement_skip_if_zero: skip_taken = (operand_ff == 8'h01);
         op_increment_skip_if_zero: skip_taken = (operand_ff == 8'hFF);
         op_bit_test_skip_if_clear: skip_taken = ~operand_ff[dec.bitpos];
         op_bit_test_skip_if_set: skip_taken = operand_ff[dec.bitpos];
         default: skip_taken = 1'b0;
      endcase
      // Only file-register forms can reach an indirect port
      extra_cycle = dec.file_op &&
                    ((dec.faddr == `INDIRECT_PORT0 && ptr_msb_ff[0]) ||
                     (dec.faddr == `INDIRECT_PORT1 && ptr_msb_ff[1]));
      cycles = ((dec.pc_mod || skip_taken) ? 2'd2 : 2'd1) + {1'b0, extra_cycle};
      disp = {{7{instr_ff[8]}}, instr_ff[8:0]};
   end

   always_comb begin
      mapped = 1'b1;
      unique case (paddr)
         `REG_INSTR: rd_word = {18'h0, instr_ff};
         `REG_OPERAND: rd_word = {22'h0, ptr_msb_ff, operand_ff};
         `REG_FIELDS: rd_word = {10'h0, dec.op, 2'h0, dec.ptr_sel, dec.dest, 1'b0, dec.bitpos, 1'b0, dec.faddr};
         `REG_LITERAL: rd_word = {21'h0, dec.lit};
         `REG_STATUS: rd_word = {23'h0, (dec.op == op_illegal), extra_cycle, skip_taken,
                                 dec.pc_mod, dec.flags, cycles};
         `REG_DISP: rd_word = {16'h0, disp};
         default: begin
            rd_word = 32'h0;
            mapped = 1'b0;
         end
      endcase
   end

   always_comb begin
      nxt_instr = instr_ff;
      nxt_operand = operand_ff;
      nxt_ptr_msb = ptr_msb_ff;
      nxt_prdata = prdata_ff;
      nxt_pslverr = 1'b0;
      // Ready is raised for exactly the first access cycle, so every transfer has one wait-free access
      nxt_pready = psel && !penable && !pready_ff;
      if (psel && !penable) begin
         nxt_prdata = pwrite ? 32'h0 : rd_word;
         nxt_pslverr = !mapped;
      end
      if (psel && penable && pready_ff && pwrite) begin
         if (paddr == `REG_INSTR) begin
            nxt_instr = pwdata[13:0];
         end
         if (paddr == `REG_OPERAND) begin
            nxt_operand = pwdata[7:0];
            nxt_ptr_msb = pwdata[`OPERAND_PTR_MSB_LSB +: 2];
         end
      end
      if (pready_ff) begin
         nxt_pslverr = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_ff <= `INSTR_RESET;
         operand_ff <= `OPERAND_RESET;
         ptr_msb_ff <= 2'h0;
         prdata_ff <= 32'h0;
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         instr_ff <= nxt_instr;
         operand_ff <= nxt_operand;
         ptr_msb_ff <= nxt_ptr_msb;
         prdata_ff <= nxt_prdata;
         pready_ff <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;

endmodule

// ---- core/decoder_regs.svh ----
// Register offsets, field positions and reset values of the instruction decoder.
// Assumes a 32-bit APB slave with one aligned word per register.
`ifndef DECODER_REGS_SVH
`define DECODER_REGS_SVH

`define REG_INSTR 8'h00
`define REG_OPERAND 8'h04
`define REG_FIELDS 8'h08
`define REG_LITERAL 8'h0C
`define REG_STATUS 8'h10
`define REG_DISP 8'h14

`define INSTR_RESET 14'h0000
`define OPERAND_RESET 8'h00

// OPERAND register fields
`define OPERAND_PTR_MSB_LSB 8
// FIELDS register fields
`define FIELDS_BITPOS_LSB 8
`define FIELDS_DEST_BIT 12
`define FIELDS_PTR_SEL_BIT 13
`define FIELDS_OP_LSB 16
// STATUS register fields
`define STATUS_FLAGS_LSB 2
`define STATUS_PC_MOD_BIT 5
`define STATUS_SKIP_BIT 6
`define STATUS_EXTRA_BIT 7
`define STATUS_ILLEGAL_BIT 8

// Flag mask bit positions inside the 3-bit flag field
`define FLAG_Z 0
`define FLAG_DIGIT_CARRY 1
`define FLAG_C 2

// File addresses of the two indirect access ports
`define INDIRECT_PORT0 7'h00
`define INDIRECT_PORT1 7'h01

`endif

// ---- core/decoder_pkg.sv ----
// Types shared by the instruction decoder and its bench.
// Assumes the constants of decoder_regs.svh for positions and offsets.
package decoder_pkg;

   typedef enum logic [5:0] {
      op_nop, op_illegal,
      op_add_acc_register, op_add_with_carry_to_register, op_and_acc_register,
      op_arith_shift_right, op_logic_shift_left, op_logic_shift_right,
      op_clear_register, op_clear_acc, op_complement_register, op_decrement_register,
      op_increment_register, op_inclusive_or_acc_register, op_move_register,
      op_move_acc_to_register, op_rotate_left_via_carry, op_rotate_right_via_carry,
      op_subtract_acc_register, op_subtract_with_borrow_register, op_swap_nibbles,
      op_exclusive_or_acc_register, op_decrement_skip_if_zero, op_increment_skip_if_zero,
      op_bit_clear, op_bit_set, op_bit_test_skip_if_clear, op_bit_test_skip_if_set,
      op_add_literal_acc, op_and_literal_acc, op_inclusive_or_literal_acc,
      op_load_bank_select, op_load_upper_counter_latch, op_move_literal_acc,
      op_subtract_acc_from_literal, op_exclusive_or_literal_acc,
      op_call, op_jump, op_relative_branch, op_pointer_add_offset, op_pointer_move_indexed
   } op_t;

   typedef struct packed {
      op_t op;
      logic dest;
      logic [2:0] bitpos;
      logic [6:0] faddr;
      logic ptr_sel;
      logic [10:0] lit;
      logic [2:0] flags;
      logic pc_mod;
      logic file_op;
   } decoded_t;

endpackage

// ---- verification/program_fetch_model.sv ----
// Program memory fetch model: hands the bench instruction words by index.
// Assumes the bench lets one clock edge pass after changing the index.
module program_fetch_model (
   input wire logic [3:0] idx,
   output logic [13:0] word
);
   // First eleven entries leave the low byte free for random fill
   always_comb begin
      case (idx)
         4'h0: word = 14'h3D00;
         4'h1: word = 14'h3BFF;
         4'h2: word = 14'h0B81;
         4'h3: word = 14'h0F01;
         4'h4: word = 14'h1B80;
         4'h5: word = 14'h1C05;
         4'h6: word = 14'h3CA5;
         4'h7: word = 14'h0680;
         4'h8: word = 14'h38FF;
         4'h9: word = 14'h0D00;
         4'hA: word = 14'h0C81;
         4'hB: word = 14'h31FF;
         4'hC: word = 14'h003F;
         default: word = 14'h0000;
      endcase
   end
endmodule

// ---- verification/decoder_monitor.sv ----
// Checker for the decoder's APB port, bound to its top module.
// Assumes one clock domain and the no-wait answer of the slave.
module decoder_monitor (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   logic rd_ok;
   assign rd_ok = pready && !pwrite && !pslverr;
   a_ready_after_setup: assert property (psel && !penable |=> pready) else $error("no answer after setup");
   a_ready_single: assert property (pready |=> !pready) else $error("ready held two cycles");
   a_ready_in_access: assert property (pready |-> psel && penable) else $error("ready outside access");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("error without ready");
   a_err_unmapped: assert property (pready && paddr > 8'h14 |-> pslverr && prdata == 32'h0) else $error("bad unmapped");
   a_no_err_mapped: assert property (pready && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("error on mapped");
   a_write_zero_data: assert property (pready && pwrite |-> prdata == 32'h0) else $error("data on write");
   a_rdata_hold: assert property (!$past(psel && !penable) |-> $stable(prdata)) else $error("read data moved");
   a_status_cycles: assert property (rd_ok && paddr == 8'h10 |->
      prdata[1:0] == 2'h1 + (prdata[5] | prdata[6]) + prdata[7]) else $error("cycle count wrong");
   a_disp_signed: assert property (rd_ok && paddr == 8'h14 |->
      prdata[15:9] == {7{prdata[8]}}) else $error("displacement not sign extended");
   cover property (rd_ok && paddr == 8'h10 && prdata[6]);
   cover property (rd_ok && paddr == 8'h10 && prdata[7]);
   cover property (pslverr);
endmodule

bind instruction_decoder decoder_monitor mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
   .pready, .pslverr);

// ---- verification/instruction_decoder_tb.sv ----
// Self-checking bench for the instruction decoder over APB.
// Assumes the register map of decoder_regs.svh and the fetch model.
`include "decoder_regs.svh"
module instruction_decoder_tb import decoder_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, e;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, q, rnd = 32'h1E;
   logic [3:0] fidx = 4'h0;
   logic [13:0] fword;
   logic [9:0] ops [3] = '{10'h301, 10'h0FF, 10'h200};
   int miscompares = 0, tests_run = 0, cyc = 0;
   instruction_decoder DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   program_fetch_model fetch (.idx(fidx), .word(fword));
   initial forever #2 pclk = ~pclk;
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   // Holds psel high on exit so transfers run back to back
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
      output logic er);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      // A slave that never answers must not slip through as a quiet pass
      if (pready !== 1'b1) chk("pready", {31'h0, pready}, 32'h1);
      r = prdata;
      er = pslverr;
      penable <= 1'b0;
   endtask
   function automatic logic [8:0] exp_dec(input logic [13:0] w);
      casez (w)
         14'b11_1101_????????: return {op_add_with_carry_to_register, 3'b111};
         14'b11_1011_????????: return {op_subtract_with_borrow_register, 3'b111};
         14'b00_1011_????????: return {op_decrement_skip_if_zero, 3'b000};
         14'b00_1111_????????: return {op_increment_skip_if_zero, 3'b000};
         14'b01_10??_????????: return {op_bit_test_skip_if_clear, 3'b000};
         14'b01_11??_????????: return {op_bit_test_skip_if_set, 3'b000};
         14'b11_0001_1???????: return {op_load_upper_counter_latch, 3'b000};
         14'b11_1100_????????: return {op_subtract_acc_from_literal, 3'b111};
         14'b00_0110_????????: return {op_exclusive_or_acc_register, 3'b001};
         14'b11_1000_????????: return {op_inclusive_or_literal_acc, 3'b001};
         14'b00_1101_????????: return {op_rotate_left_via_carry, 3'b100};
         14'b00_1100_????????: return {op_rotate_right_via_carry, 3'b100};
         14'b00_0000_001?????: return {op_load_bank_select, 3'b000};
         default: return 9'h1FF;
      endcase
   endfunction
   task automatic run_word(input logic [13:0] w, input logic [9:0] opnd);
      logic [8:0] ex;
      logic fop, skip, xtra;
      logic [1:0] cy;
      ex = exp_dec(w);
      fop = (w[13:12] != 2'h3 || w[13:8] == 6'h3D || w[13:8] == 6'h3B) && w[13:5] != 9'h001;
      skip = (ex[8:3] == op_decrement_skip_if_zero && opnd[7:0] == 8'h01)
         || (ex[8:3] == op_increment_skip_if_zero && opnd[7:0] == 8'hFF)
         || (ex[8:3] == op_bit_test_skip_if_clear && !opnd[w[9:7]])
         || (ex[8:3] == op_bit_test_skip_if_set && opnd[w[9:7]]);
      xtra = fop && ((w[6:0] == 7'h00 && opnd[8]) || (w[6:0] == 7'h01 && opnd[9]));
      cy = 2'h1 + skip + xtra;
      xfer(1'b1, `REG_INSTR, {18'h0, w}, q, e);
      xfer(1'b1, `REG_OPERAND, {22'h0, opnd}, q, e);
      // Read-only place: the write must leave the decode untouched
      xfer(1'b1, `REG_FIELDS, 32'hFFFFFFFF, q, e);
      xfer(1'b0, `REG_FIELDS, 32'h0, q, e);
      chk("op", {26'h0, q[21:16]}, {26'h0, ex[8:3]});
      if (fop) chk("faddr", {25'h0, q[6:0]}, {25'h0, w[6:0]});
      if (w[13:12] == 2'h1) chk("bitpos", {29'h0, q[10:8]}, {29'h0, w[9:7]});
      else if (fop) chk("dest", {31'h0, q[12]}, {31'h0, w[7]});
      xfer(1'b0, `REG_STATUS, 32'h0, q, e);
      chk("status", q, {23'h0, 1'b0, xtra, skip, 1'b0, ex[2:0], cy});
      xfer(1'b0, `REG_LITERAL, 32'h0, q, e);
      if (!fop) chk("literal", q, w[13:8] == 6'h31 ? {25'h0, w[6:0]} :
         (w[13:5] == 9'h001 ? {27'h0, w[4:0]} : {24'h0, w[7:0]}));
      xfer(1'b0, `REG_DISP, 32'h0, q, e);
      chk("disp", q, {16'h0, {7{w[8]}}, w[8:0]});
      psel <= 1'b0;
   endtask
   // Counter-changing and unlisted words, which the fetch table never holds
   task automatic run_ctrl(input logic [13:0] w, input logic [31:0] st, input logic [31:0] lit);
      xfer(1'b1, `REG_INSTR, {18'h0, w}, q, e);
      xfer(1'b0, `REG_STATUS, 32'h0, q, e);
      chk("ctrl status", q, st);
      xfer(1'b0, `REG_LITERAL, 32'h0, q, e);
      chk("ctrl literal", q, lit);
      xfer(1'b0, `REG_DISP, 32'h0, q, e);
      chk("ctrl disp", q, {16'h0, {7{w[8]}}, w[8:0]});
      psel <= 1'b0;
      @(posedge pclk);
   endtask
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 8000) begin
         miscompares++;
         give_verdict();
      end
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      xfer(1'b0, `REG_STATUS, 32'h0, q, e);
      chk("reset status", q, 32'h00000001);
      xfer(1'b1, 8'h18, 32'h1, q, e);
      chk("write err", {31'h0, e}, 32'h1);
      xfer(1'b0, 8'h1C, 32'h0, q, e);
      chk("read err", {31'h0, e}, 32'h1);
      chk("read err data", q, 32'h0);
      psel <= 1'b0;
      $display("reset and unmapped done");
      for (int i = 0; i < 13; i++) begin
         for (int j = 0; j < 3; j++) begin
            fidx = i[3:0];
            @(posedge pclk);
            run_word(fword, ops[j]);
         end
      end
      $display("corner words done");
      run_ctrl(14'h3380, 32'h00000022, 32'h00000180);
      run_ctrl(14'h2ABC, 32'h00000022, 32'h000002BC);
      run_ctrl(14'h22BC, 32'h00000022, 32'h000002BC);
      run_ctrl(14'h0008, 32'h00000101, 32'h00000000);
      $display("control words done");
      repeat (60) begin
         rnd = xs(rnd);
         fidx = 4'(rnd % 11);
         @(posedge pclk);
         run_word({fword[13:8], rnd[15:8]}, rnd[25:16]);
      end
      $display("random words done");
      give_verdict();
   end
endmodule
